//--- design/bmh_arbiter.sv
// bus mastership handshake: grant, release and retake of the bus
// Summary of operation
// - grant follows a bus request after 1.5 to 3.5 clocks
// - grant withdrawn 1.5 to 3.5 clocks after request negates
// - grant withdrawn 1.5 to 3.5 clocks after grant acknowledge asserts
// - request held past that window may bring the grant back
// - strobes and read/write undriven 1.5 clocks after acknowledge negates
// - function code and memory valid undriven 1 clock after acknowledge ends
// - request dropped unacknowledged: strobes undriven at least 1.5 clocks
// - request dropped unacknowledged: function code undriven at least 1 clock
// - request dropped before acknowledge: negate grant, retake the bus
// - request, acknowledge and status inputs sampled each clock
`timescale 1ns/10ps

module bmh_arbiter (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_b,
    // arbitration pins
    input  wire logic        bus_request_n,
    input  wire logic        grant_ack_n,
    output logic             bus_grant_n,
    // status pins
    input  wire logic        bus_error_n,
    input  wire logic        transfer_ack_n,
    input  wire logic [2:0]  interrupt_level_n,
    input  wire logic        valid_periph_addr_n,
    // core side
    input  wire logic        cycle_active,
    output logic             bus_avail,
    output logic             bus_error_s_n,
    output logic             transfer_ack_s_n,
    output logic [2:0]       interrupt_level_s_n,
    output logic             valid_periph_addr_s_n,
    // drive enables, high while this end drives
    output logic             bus_ctl_oe,
    output logic             fc_vma_oe
);

    logic [bmh_pkg::SMP_W-1:0] smp;
    logic                      s_req_n;
    logic                      s_ack_n;

    bmh_sampler u_sampler (
        .mclk  (mclk),
        .rst_b (rst_b),
        .pins  ({bus_request_n, grant_ack_n, bus_error_n, transfer_ack_n,
                 interrupt_level_n, valid_periph_addr_n}),
        .smp   (smp)
    );

    assign s_req_n               = smp[bmh_pkg::SMP_REQ];
    assign s_ack_n               = smp[bmh_pkg::SMP_ACK];
    assign bus_error_s_n         = smp[bmh_pkg::SMP_BUS_ERROR_N];
    assign transfer_ack_s_n      = smp[bmh_pkg::SMP_TRANSFER_ACK_N];
    assign interrupt_level_s_n   = smp[bmh_pkg::SMP_IPL_H:bmh_pkg::SMP_IPL_L];
    assign valid_periph_addr_s_n = smp[bmh_pkg::SMP_VPA];

    bmh_pkg::bmh_state_t             st;
    bmh_pkg::bmh_state_t             next_st;
    logic [bmh_pkg::CNT_W-1:0]       cnt;
    logic [bmh_pkg::CNT_W-1:0]       next_cnt;
    logic                            fin;
    logic                            next_fin;
    logic                            next_bus_grant_n;
    logic                            next_bus_ctl_oe;
    logic                            next_fc_vma_oe;
    logic                            regrant;

    // core may start a cycle only while this end owns the bus
    assign bus_avail = (st == bmh_pkg::BMH_OWN);

    always_comb begin
        next_st  = st;
        next_cnt = cnt;
        next_fin = fin;
        unique case (st)
            bmh_pkg::BMH_OWN: begin
                next_fin = cycle_active;
                next_cnt = bmh_pkg::CNT_ZERO;
                if (!s_req_n) begin
                    next_st = bmh_pkg::BMH_GRANT;
                end
            end
            bmh_pkg::BMH_GRANT: begin
                // a running cycle finishes, none may start
                next_fin = fin & cycle_active;
                next_cnt = bmh_pkg::CNT_ZERO;
                if (!s_ack_n) begin
                    next_st = bmh_pkg::BMH_ALT;
                end else if (s_req_n) begin
                    next_st = bmh_pkg::BMH_BACK;
                end
            end
            bmh_pkg::BMH_ALT: begin
                next_fin = 1'b0;
                if (s_ack_n) begin
                    next_st  = bmh_pkg::BMH_BACK;
                    next_cnt = bmh_pkg::CNT_ZERO;
                end else if (s_req_n) begin
                    next_cnt = bmh_pkg::CNT_ZERO;
                end else if (cnt < bmh_pkg::REQ_WIN_CYC + bmh_pkg::PIPE_CYC) begin
                    // count a request held past acknowledge
                    next_cnt = cnt + bmh_pkg::CNT_ONE;
                end
            end
            bmh_pkg::BMH_BACK: begin
                next_fin = 1'b0;
                // hold off driving before taking the bus back
                if (cnt < bmh_pkg::STB_CYC) begin
                    next_cnt = cnt + bmh_pkg::CNT_ONE;
                end else begin
                    next_st  = bmh_pkg::BMH_OWN;
                    next_cnt = bmh_pkg::CNT_ZERO;
                end
            end
        endcase
    end

    // window is widened by the pipeline so a timely drop never regrants
    assign regrant = (next_st == bmh_pkg::BMH_ALT) && !s_req_n &&
                     (next_cnt == bmh_pkg::REQ_WIN_CYC + bmh_pkg::PIPE_CYC);

    always_comb begin
        next_bus_grant_n = !((next_st == bmh_pkg::BMH_GRANT) || regrant);
        // strobes stay off through the whole recovery
        next_bus_ctl_oe  = (next_st == bmh_pkg::BMH_OWN) ||
                           ((next_st == bmh_pkg::BMH_GRANT) && next_fin);
        // function code returns two clocks earlier
        next_fc_vma_oe   = next_bus_ctl_oe ||
                           ((next_st == bmh_pkg::BMH_BACK) &&
                            (next_cnt >= bmh_pkg::FC_CYC));
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st          <= bmh_pkg::BMH_OWN;
            cnt         <= bmh_pkg::CNT_ZERO;
            fin         <= 1'b0;
            bus_grant_n <= 1'b1;
            bus_ctl_oe  <= 1'b1;
            fc_vma_oe   <= 1'b1;
        end else begin
            st          <= next_st;
            cnt         <= next_cnt;
            fin         <= next_fin;
            bus_grant_n <= next_bus_grant_n;
            bus_ctl_oe  <= next_bus_ctl_oe;
            fc_vma_oe   <= next_fc_vma_oe;
        end
    end

    sequence s_req_seen;
        (st == bmh_pkg::BMH_OWN) && !bus_request_n && grant_ack_n;
    endsequence

    property p_grant_on_req;
        @(posedge mclk) disable iff (!rst_b)
        s_req_seen |-> ##2 !bus_grant_n;
    endproperty
    a_grant_on_req: assert property (p_grant_on_req)
        else $error("grant late after request");

    property p_grant_off_req;
        @(posedge mclk) disable iff (!rst_b)
        (!bus_grant_n && $rose(bus_request_n) && grant_ack_n)
            |-> ##[2:3] bus_grant_n;
    endproperty
    a_grant_off_req: assert property (p_grant_off_req)
        else $error("grant not withdrawn after request negated");

    property p_grant_off_ack;
        @(posedge mclk) disable iff (!rst_b)
        (st == bmh_pkg::BMH_GRANT && $fell(grant_ack_n))
            |-> ##[2:3] bus_grant_n;
    endproperty
    a_grant_off_ack: assert property (p_grant_off_ack)
        else $error("grant not withdrawn after acknowledge");

    sequence s_ack_end;
        (st == bmh_pkg::BMH_ALT) && $rose(grant_ack_n);
    endsequence

    property p_strobe_hold;
        @(posedge mclk) disable iff (!rst_b)
        s_ack_end |-> !bus_ctl_oe [*3];
    endproperty
    a_strobe_hold: assert property (p_strobe_hold)
        else $error("strobes driven too soon after acknowledge");

    property p_fc_hold;
        @(posedge mclk) disable iff (!rst_b)
        s_ack_end |-> !fc_vma_oe ##1 !fc_vma_oe;
    endproperty
    a_fc_hold: assert property (p_fc_hold)
        else $error("function code driven too soon after acknowledge");

    property p_unack_strobe;
        @(posedge mclk) disable iff (!rst_b)
        (st == bmh_pkg::BMH_GRANT && !bus_ctl_oe && $rose(bus_request_n))
            |-> !bus_ctl_oe [*3];
    endproperty
    a_unack_strobe: assert property (p_unack_strobe)
        else $error("strobes driven too soon after request dropped");

    property p_unack_fc;
        @(posedge mclk) disable iff (!rst_b)
        (st == bmh_pkg::BMH_GRANT && !fc_vma_oe && $rose(bus_request_n))
            |-> ##1 !fc_vma_oe;
    endproperty
    a_unack_fc: assert property (p_unack_fc)
        else $error("function code driven too soon after request dropped");

    property p_retake;
        @(posedge mclk) disable iff (!rst_b)
        (st == bmh_pkg::BMH_GRANT && grant_ack_n && $rose(bus_request_n))
            ##1 grant_ack_n |-> ##[1:8] (fc_vma_oe && bus_grant_n);
    endproperty
    a_retake: assert property (p_retake)
        else $error("bus not retaken after request withdrawn");

    property p_regrant;
        @(posedge mclk) disable iff (!rst_b)
        ((st == bmh_pkg::BMH_ALT) && !bus_request_n && !grant_ack_n) [*3]
            |-> ##[0:2] !bus_grant_n;
    endproperty
    a_regrant: assert property (p_regrant)
        else $error("held request not regranted");

    property p_grant_min;
        @(posedge mclk) disable iff (!rst_b)
        (st == bmh_pkg::BMH_OWN) && $fell(bus_request_n) && grant_ack_n
            |=> bus_grant_n;
    endproperty
    a_grant_min: assert property (p_grant_min)
        else $error("grant asserted too soon after request");

    property p_grant_off_min;
        @(posedge mclk) disable iff (!rst_b)
        (st == bmh_pkg::BMH_GRANT) && $rose(bus_request_n) &&
            grant_ack_n && $stable(grant_ack_n) |=> !bus_grant_n;
    endproperty
    a_grant_off_min: assert property (p_grant_off_min)
        else $error("grant withdrawn too soon after request negated");

    property p_ack_off_min;
        @(posedge mclk) disable iff (!rst_b)
        (st == bmh_pkg::BMH_GRANT) && $fell(grant_ack_n) &&
            !bus_request_n && $stable(bus_request_n) |=> !bus_grant_n;
    endproperty
    a_ack_off_min: assert property (p_ack_off_min)
        else $error("grant withdrawn too soon after acknowledge");

    property p_alt_window;
        @(posedge mclk) disable iff (!rst_b)
        $rose(st == bmh_pkg::BMH_ALT) |-> bus_grant_n [*3];
    endproperty
    a_alt_window: assert property (p_alt_window)
        else $error("grant returned inside the acknowledge window");

    property p_alt_undriven;
        @(posedge mclk) disable iff (!rst_b)
        (st == bmh_pkg::BMH_ALT) |-> !bus_ctl_oe && !fc_vma_oe;
    endproperty
    a_alt_undriven: assert property (p_alt_undriven)
        else $error("bus driven while the alternate master owns it");

    property p_back_len;
        @(posedge mclk) disable iff (!rst_b)
        $rose(st == bmh_pkg::BMH_BACK)
            |-> (st == bmh_pkg::BMH_BACK) [*3] ##1 (st == bmh_pkg::BMH_OWN);
    endproperty
    a_back_len: assert property (p_back_len)
        else $error("recovery interval has the wrong length");

    sequence s_ctl_return;
        !bus_ctl_oe ##1 !bus_ctl_oe ##1 bus_ctl_oe;
    endsequence

    property p_fc_first;
        @(posedge mclk) disable iff (!rst_b)
        $rose(fc_vma_oe) && (st == bmh_pkg::BMH_BACK) |-> s_ctl_return;
    endproperty
    a_fc_first: assert property (p_fc_first)
        else $error("function code and strobes return out of order");

    property p_own_drives;
        @(posedge mclk) disable iff (!rst_b)
        (st == bmh_pkg::BMH_OWN) |-> bus_ctl_oe && fc_vma_oe && bus_grant_n;
    endproperty
    a_own_drives: assert property (p_own_drives)
        else $error("bus not driven while this end owns it");

    property p_grant_refuse;
        @(posedge mclk) disable iff (!rst_b)
        (st == bmh_pkg::BMH_GRANT) && !fin |=> !bus_ctl_oe;
    endproperty
    a_grant_refuse: assert property (p_grant_refuse)
        else $error("bus driven after grant with no cycle running");

endmodule

//--- design/bmh_pkg.sv
// constants for the bus mastership handshake block
package bmh_pkg;

    // times in tenths of a processor clock; mclk is the processor clock
    localparam int ARB_MIN_X10 = 15;
    localparam int ARB_MAX_X10 = 35;
    localparam int STB_DRV_X10 = 15;
    localparam int FC_DRV_X10  = 10;
    localparam int REQ_WIN_X10 = 15;

    localparam int CNT_W = 3;

    // least times round up, longest times round down
    localparam logic [CNT_W-1:0] ARB_MIN_CYC = CNT_W'((ARB_MIN_X10 + 9) / 10);
    localparam logic [CNT_W-1:0] ARB_MAX_CYC = CNT_W'(ARB_MAX_X10 / 10);
    localparam logic [CNT_W-1:0] STB_CYC     = CNT_W'((STB_DRV_X10 + 9) / 10);
    localparam logic [CNT_W-1:0] FC_CYC      = CNT_W'((FC_DRV_X10 + 9) / 10);
    localparam logic [CNT_W-1:0] REQ_WIN_CYC = CNT_W'(REQ_WIN_X10 / 10);
    // input sampling plus state register latency
    localparam logic [CNT_W-1:0] PIPE_CYC    = 3'h2;
    localparam logic [CNT_W-1:0] CNT_ZERO    = 3'h0;
    localparam logic [CNT_W-1:0] CNT_ONE     = 3'h1;

    // sampled input vector layout
    localparam int SMP_W     = 8;
    localparam int SMP_REQ   = 7;
    localparam int SMP_ACK   = 6;
    localparam int SMP_BUS_ERROR_N  = 5;
    localparam int SMP_TRANSFER_ACK_N = 4;
    localparam int SMP_IPL_H = 3;
    localparam int SMP_IPL_L = 1;
    localparam int SMP_VPA   = 0;
    localparam logic [SMP_W-1:0] SMP_RST = 8'hFF;

    typedef enum logic [1:0] {
        BMH_OWN,
        BMH_GRANT,
        BMH_ALT,
        BMH_BACK
    } bmh_state_t;

endpackage

//--- design/bmh_sampler.sv
// input sampling stage for the arbitration and bus status pins
`timescale 1ns/10ps

module bmh_sampler (
    // clock and reset
    input  wire logic                           mclk,
    input  wire logic                           rst_b,
    // raw pins
    input  wire logic [bmh_pkg::SMP_W-1:0]      pins,
    // captured values
    output logic      [bmh_pkg::SMP_W-1:0]      smp
);

    logic [bmh_pkg::SMP_W-1:0] next_smp;

    always_comb begin
        next_smp = pins;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            smp <= bmh_pkg::SMP_RST;
        end else begin
            smp <= next_smp;
        end
    end

    property p_sample_follows;
        @(posedge mclk) disable iff (!rst_b)
        $changed(pins) |=> (smp == $past(pins)) ##1 (smp == $past(pins));
    endproperty
    a_sample_follows: assert property (p_sample_follows)
        else $error("sampled pins do not follow raw pins");

endmodule

//--- dv/bmh_alt_master.sv
// alternate bus master model facing the arbitration pins
`timescale 1ns/10ps

module bmh_alt_master (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst_b,
    // bench control
    input  wire logic go,
    input  wire logic abort,
    input  wire logic hold,
    // arbitration pins
    input  wire logic bus_grant_n,
    output logic      bus_request_n,
    output logic      grant_ack_n
);
    always @(posedge mclk) begin
        if (!rst_b) begin
            bus_request_n <= 1'b1;
            grant_ack_n <= 1'b1;
        end else if (go) begin
            bus_request_n <= 1'b0;
            for (int n = 0; n < 8 && bus_grant_n !== 1'b0; n++) begin
                @(posedge mclk);
            end
            // answer one clock late, not at once
            @(posedge mclk);
            if (abort) begin
                bus_request_n <= 1'b1;
            end else begin
                grant_ack_n <= 1'b0;
                @(posedge mclk);
                // drop one clock after acknowledge
                // 20 ns cannot fit inside 1.5 clocks at this rate
                bus_request_n <= ~hold;
                repeat (6) @(posedge mclk);
                bus_request_n <= 1'b1;
                grant_ack_n <= 1'b1;
            end
        end
    end
endmodule

//--- dv/bus_mastership_handshake_tb_top.sv
// self-checking bench for the bus mastership handshake
`timescale 1ns/10ps

module bus_mastership_handshake_tb_top;
    logic       mclk = 1'b0;
    logic       rst_b = 1'b0;
    logic       go = 1'b0;
    logic       abort = 1'b0;
    logic       hold = 1'b0;
    logic       cycle_active = 1'b0;
    logic       bus_error_n = 1'b1;
    logic       transfer_ack_n = 1'b1;
    logic [2:0] interrupt_level_n = 3'h7;
    logic       valid_periph_addr_n = 1'b1;
    logic       bus_request_n, grant_ack_n, bus_grant_n;
    logic       bus_avail, bus_ctl_oe, fc_vma_oe;
    logic [5:0] stat_s;
    int         err_total = 0;
    int         check_count = 0;
    int         cyc = 0;
    int         ev [8];
    int         regrant, bad, ctl_off, fc_off;

    always #4 mclk = ~mclk;

    bmh_arbiter uut (
        .mclk(mclk), .rst_b(rst_b),
        .bus_request_n(bus_request_n), .grant_ack_n(grant_ack_n),
        .bus_grant_n(bus_grant_n), .bus_error_n(bus_error_n),
        .transfer_ack_n(transfer_ack_n),
        .interrupt_level_n(interrupt_level_n),
        .valid_periph_addr_n(valid_periph_addr_n),
        .cycle_active(cycle_active), .bus_avail(bus_avail),
        .bus_error_s_n(stat_s[5]), .transfer_ack_s_n(stat_s[4]),
        .interrupt_level_s_n(stat_s[3:1]),
        .valid_periph_addr_s_n(stat_s[0]),
        .bus_ctl_oe(bus_ctl_oe), .fc_vma_oe(fc_vma_oe)
    );

    bmh_alt_master alt (
        .mclk(mclk), .rst_b(rst_b), .go(go), .abort(abort), .hold(hold),
        .bus_grant_n(bus_grant_n), .bus_request_n(bus_request_n),
        .grant_ack_n(grant_ack_n)
    );

    task automatic finish_test();
        $display("errors %0d checks %0d", err_total, check_count);
        if (err_total == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk_rng(input int got, input int lo, input int hi);
        check_count++;
        if (got < lo || got > hi) begin
            err_total++;
            $display("[FAIL] %0t got %0h want %0h..%0h", $time, got, lo, hi);
        end
    endtask

    task automatic chk_val(input logic [5:0] got, input logic [5:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %0h want %0h", $time, got, exp);
        end
    endtask

    task automatic mark(input int i, input logic c, input int k);
        if (ev[i] < 0 && c) ev[i] = k;
    endtask

    // edge numbers: request, grant, ack, grant off, ack off,
    // request off, fc back, strobes back
    task automatic run(input logic a, input logic h, input int ca);
        ev = '{default: -1};
        regrant = 0;
        bad = 0;
        ctl_off = 0;
        fc_off = 0;
        // one edge apart from the last run's final drive
        @(posedge mclk);
        go <= 1'b1;
        abort <= a;
        hold <= h;
        cycle_active <= (ca > 0);
        for (int k = 1; k <= 40; k++) begin
            @(posedge mclk);
            go <= 1'b0;
            if (k == ca) cycle_active <= 1'b0;
            ctl_off |= (bus_ctl_oe === 1'b0);
            fc_off |= (fc_vma_oe === 1'b0);
            mark(0, bus_request_n === 1'b0, k);
            mark(1, bus_grant_n === 1'b0, k);
            mark(2, grant_ack_n === 1'b0, k);
            mark(3, ev[1] >= 0 && bus_grant_n === 1'b1, k);
            mark(4, ev[2] >= 0 && grant_ack_n === 1'b1, k);
            mark(5, ev[0] >= 0 && bus_request_n === 1'b1, k);
            mark(6, fc_off != 0 && fc_vma_oe === 1'b1, k);
            mark(7, ctl_off != 0 && bus_ctl_oe === 1'b1, k);
            if (ev[3] >= 0 && bus_grant_n === 1'b0) regrant = 1;
            // an ongoing cycle must not lose its strobes
            if (cycle_active === 1'b1 && bus_ctl_oe === 1'b0) bad = 1;
            if (ev[2] >= 0 && ev[4] < 0 && bus_ctl_oe !== 1'b0) bad = 1;
            if (ev[2] >= 0 && ev[4] < 0 && bus_avail !== 1'b0) bad = 1;
        end
    endtask

    task automatic t_handover();
        run(1'b0, 1'b0, 4);
        chk_rng(ev[1] - ev[0], 2, 3);
        chk_rng(ev[3] - ev[2], 2, 3);
        chk_rng(ev[7] - ev[4], 2, 6);
        chk_rng(ev[6] - ev[4], 1, 6);
        chk_rng(bad + regrant, 0, 0);
    endtask

    task automatic t_abort();
        run(1'b1, 1'b0, 0);
        chk_rng(ev[2], -1, -1);
        chk_rng(ev[3] - ev[5], 2, 3);
        chk_rng(ev[7] - ev[5], 2, 8);
        chk_rng(ev[6] - ev[5], 1, 8);
        chk_val({5'h00, bus_avail}, 6'h01);
    endtask

    task automatic t_regrant();
        run(1'b0, 1'b1, 0);
        chk_rng(regrant, 1, 1);
        chk_rng(bad, 0, 0);
    endtask

    task automatic t_status();
        logic [5:0] p;
        for (int i = 0; i < 8; i++) begin
            p = (i < 6) ? ~(6'h01 << i) : {6{i[0]}};
            {bus_error_n, transfer_ack_n, interrupt_level_n,
             valid_periph_addr_n} <= p;
            repeat (2) @(posedge mclk);
            chk_val(stat_s, p);
        end
    endtask

    // hang guard, far above the expected 156 or so cycles
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            finish_test();
        end
    end

    initial begin
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        t_handover();
        t_abort();
        t_regrant();
        t_status();
        finish_test();
    end
endmodule
